// ---- hdl/xdl_scroll_map_cmds.sv ----
// operand fetch and apply for text scroll, glyph base, map locate and map params commands
`timescale 1ns/10ps
`default_nettype none
module xdl_scroll_map_cmds
    import xdl_cmd_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // raster timing
    input wire logic frame_start,
    input wire logic line_done,
    // command handoff
    input wire logic cmd_valid,
    input wire cmd_flags_t cmd_flags,
    output logic cmd_ready,
    // operand bytes from the display list
    output logic fetch_req,
    input wire logic fetch_ack,
    input wire logic [7:0] fetch_data,
    // applied settings
    output text_scroll_t text_scroll,
    output logic [VRAM_ADDR_W-1:0] font_addr,
    output attr_map_t attr_map
);

    fetch_state_t state;
    fetch_state_t next_state;
    cmd_flags_t pending;
    cmd_flags_t next_pending;
    logic [IDX_W-1:0] idx;
    logic [IDX_W-1:0] next_idx;
    logic [IDX_W-1:0] last_idx;
    logic [7:0] shadow0;
    logic [7:0] shadow1;
    logic [7:0] shadow2;
    logic [7:0] shadow3;
    logic [MAP_FIELD_W-1:0] field_row;
    logic take;
    logic locate_commit;
    logic field_end;
    logic [VRAM_ADDR_W-1:0] map_pointer;
    logic [STRIDE_W-1:0] map_stride;
    logic [MAP_FIELD_W-1:0] map_hscroll;
    logic [MAP_FIELD_W-1:0] map_vscroll;
    logic [MAP_FIELD_W-1:0] map_width;
    logic [MAP_FIELD_W-1:0] map_height;

    assign take = fetch_req && fetch_ack;
    assign locate_commit = take && state == ST_LOCATE && idx == LOCATE_LAST_IDX;
    assign field_end = line_done && field_row >= attr_map.height;

    // output carrier built straight from the map flip-flops
    assign attr_map = '{
        attr_map_pointer: map_pointer,
        attr_map_stride: map_stride,
        hscroll: map_hscroll,
        vscroll: map_vscroll,
        width: map_width,
        height: map_height
    };

    // first command still waiting, in fetch order
    function automatic fetch_state_t first_pending(input cmd_flags_t f);
        if (f.text_scroll_load_cmd) begin
            first_pending = ST_TEXT;
        end else if (f.glyph_base_cmd) begin
            first_pending = ST_GLYPH;
        end else if (f.attr_map_locate_cmd) begin
            first_pending = ST_LOCATE;
        end else if (f.attr_map_params_cmd) begin
            first_pending = ST_PARAMS;
        end else begin
            first_pending = ST_IDLE;
        end
    endfunction

    always_comb begin
        unique case (state)
            ST_TEXT: last_idx = TEXT_LAST_IDX;
            ST_GLYPH: last_idx = GLYPH_LAST_IDX;
            ST_LOCATE: last_idx = LOCATE_LAST_IDX;
            ST_PARAMS: last_idx = PARAMS_LAST_IDX;
            default: last_idx = '0;
        endcase
    end

    always_comb begin
        next_state = state;
        next_pending = pending;
        next_idx = idx;
        if (state == ST_IDLE) begin
            if (cmd_valid && cmd_ready) begin
                next_pending = cmd_flags;
                next_state = first_pending(cmd_flags);
                next_idx = '0;
            end
        end else if (take) begin
            if (idx == last_idx) begin
                unique case (state)
                    ST_TEXT: next_pending.text_scroll_load_cmd = 1'b0;
                    ST_GLYPH: next_pending.glyph_base_cmd = 1'b0;
                    ST_LOCATE: next_pending.attr_map_locate_cmd = 1'b0;
                    ST_PARAMS: next_pending.attr_map_params_cmd = 1'b0;
                    default: next_pending = pending;
                endcase
                next_state = first_pending(next_pending);
                next_idx = '0;
            end else begin
                next_idx = idx + 3'h1;
            end
        end
    end

    // sequencer
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            pending <= '0;
            idx <= '0;
            fetch_req <= 1'b0;
            cmd_ready <= 1'b1;
        end else begin
            state <= next_state;
            pending <= next_pending;
            idx <= next_idx;
            fetch_req <= next_state != ST_IDLE;
            cmd_ready <= next_state == ST_IDLE;
        end
    end

    // text scroll: stored only, applied every line; step is one hires pixel
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            text_scroll <= '{hscroll: TEXT_SCROLL_RESET, vscroll: TEXT_SCROLL_RESET};
        end else if (frame_start) begin
            text_scroll.hscroll <= TEXT_SCROLL_RESET;
            text_scroll.vscroll <= TEXT_SCROLL_RESET;
        end else if (take && state == ST_TEXT) begin
            if (idx == 3'h0) begin
                text_scroll.hscroll <= fetch_data[TEXT_SCROLL_W-1:0];
            end else begin
                text_scroll.vscroll <= fetch_data[TEXT_SCROLL_W-1:0];
            end
        end
    end

    // font base on a 2K boundary
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            font_addr <= {GLYPH_SEL_RESET, {GLYPH_ZERO_BITS{1'b0}}};
        end else if (take && state == ST_GLYPH) begin
            font_addr <= {fetch_data, {GLYPH_ZERO_BITS{1'b0}}};
        end
    end

    // locate operand bytes held until the whole set is in
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            shadow0 <= 8'h00;
            shadow1 <= 8'h00;
            shadow2 <= 8'h00;
            shadow3 <= 8'h00;
        end else if (take && state == ST_LOCATE) begin
            unique case (idx)
                3'h0: shadow0 <= fetch_data;
                3'h1: shadow1 <= fetch_data;
                3'h2: shadow2 <= fetch_data;
                3'h3: shadow3 <= fetch_data;
                default: shadow0 <= shadow0;
            endcase
        end
    end

    // map pointer and stride; a new locate overrides the automatic step
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            map_pointer <= MAP_PTR_RESET;
            map_stride <= STRIDE_RESET;
        end else if (locate_commit) begin
            map_pointer <= {shadow2[2:0], shadow1, shadow0};
            map_stride <= {fetch_data[3:0], shadow3};
        end else if (field_end && !frame_start) begin
            map_pointer <= map_pointer
                + {{(VRAM_ADDR_W-STRIDE_W){1'b0}}, map_stride};
        end
    end

    // line within the current attribute field, offset by the map vscroll
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            field_row <= '0;
        end else if (frame_start) begin
            field_row <= '0;
        end else if (locate_commit) begin
            field_row <= attr_map.vscroll;
        end else if (field_end) begin
            field_row <= '0;
        end else if (line_done) begin
            field_row <= field_row + 5'h01;
        end
    end

    // map scroll and field size: stored only, accepted on any line
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            map_hscroll <= MAP_SCROLL_RESET;
            map_vscroll <= MAP_SCROLL_RESET;
            map_width <= FIELD_SIZE_RESET;
            map_height <= FIELD_SIZE_RESET;
        end else if (frame_start) begin
            map_hscroll <= MAP_SCROLL_RESET;
            map_vscroll <= MAP_SCROLL_RESET;
            map_width <= FIELD_SIZE_RESET;
            map_height <= FIELD_SIZE_RESET;
        end else if (take && state == ST_PARAMS) begin
            unique case (idx)
                3'h0: map_hscroll <= fetch_data[MAP_FIELD_W-1:0];
                3'h1: map_vscroll <= fetch_data[MAP_FIELD_W-1:0];
                3'h2: map_width <= fetch_data[MAP_FIELD_W-1:0];
                3'h3: map_height <= fetch_data[MAP_FIELD_W-1:0];
                default: map_hscroll <= map_hscroll;
            endcase
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence text_first_s;
        take && state == ST_TEXT && idx == 3'h0 && !frame_start;
    endsequence

    sequence text_second_s;
        state == ST_TEXT && idx == 3'h1;
    endsequence

    sequence locate_done_s;
        locate_commit && !frame_start;
    endsequence

    text_order_a: assert property (text_first_s |=> text_second_s ##0
        text_scroll.hscroll == $past(fetch_data[2:0]))
        else $error("text hscroll not taken from first operand");

    text_vert_a: assert property (take && state == ST_TEXT && idx == 3'h1
        && !frame_start |=> text_scroll.vscroll == $past(fetch_data[2:0]) && state != ST_TEXT)
        else $error("text vscroll not taken from second operand");

    text_frame_a: assert property (frame_start |=> text_scroll == '0)
        else $error("text scroll not cleared at frame top");

    glyph_addr_a: assert property (take && state == ST_GLYPH
        |=> font_addr == {$past(fetch_data), 11'h000})
        else $error("font address not selector above eleven zeros");

    locate_ptr_a: assert property (locate_done_s |=> attr_map.attr_map_stride
        == {$past(fetch_data[3:0]), $past(shadow3)} && field_row == attr_map.vscroll
        && attr_map.attr_map_pointer == {$past(shadow2[2:0]), $past(shadow1), $past(shadow0)})
        else $error("map locate operands misassembled");

    map_step_a: assert property (field_end && !locate_commit && !frame_start
        |=> attr_map.attr_map_pointer == $past(attr_map.attr_map_pointer)
        + 19'($past(attr_map.attr_map_stride)) && field_row == 5'h00)
        else $error("map pointer not stepped after field end");

    map_hold_a: assert property (line_done && !field_end && !locate_commit
        |=> $stable(attr_map.attr_map_pointer))
        else $error("map pointer moved inside a field");

    map_frame_a: assert property (frame_start |=> attr_map.hscroll == 5'h00
        && attr_map.vscroll == 5'h00 && attr_map.width == 5'h07
        && attr_map.height == 5'h07)
        else $error("map defaults not restored at frame top");

    params_last_a: assert property (take && state == ST_PARAMS && idx == 3'h3
        && !frame_start |=> attr_map.height == $past(fetch_data[4:0]) && state != ST_PARAMS)
        else $error("field height not taken from fourth operand");

    params_first_a: assert property (take && state == ST_PARAMS && idx == 3'h0
        && !frame_start |=> attr_map.hscroll == $past(fetch_data[4:0]))
        else $error("map hscroll not taken from first operand");

    params_second_a: assert property (take && state == ST_PARAMS && idx == 3'h1
        && !frame_start |=> attr_map.vscroll == $past(fetch_data[4:0]))
        else $error("map vscroll not taken from second operand");

    params_third_a: assert property (take && state == ST_PARAMS && idx == 3'h2
        && !frame_start |=> attr_map.width == $past(fetch_data[4:0]))
        else $error("field width not taken from third operand");

    locate_stage_a: assert property (take && state == ST_LOCATE && idx != 3'h4
        && !field_end |=> $stable(attr_map.attr_map_pointer)
        && $stable(attr_map.attr_map_stride))
        else $error("map location changed before its last operand");

    field_count_a: assert property (line_done && !field_end && !locate_commit
        && !frame_start |=> field_row == $past(field_row) + 5'h01)
        else $error("field line counter not advanced");

    frame_ptr_a: assert property (frame_start && !locate_commit
        |=> $stable(attr_map.attr_map_pointer))
        else $error("map pointer stepped at frame top");

    ready_fetch_a: assert property (cmd_ready == !fetch_req ##0 cmd_ready == (state == ST_IDLE))
        else $error("ready and fetch request disagree");

endmodule // xdl_scroll_map_cmds
`default_nettype wire

// ---- hdl/xdl_cmd_pkg.sv ----
// shared constants and carriers for the display-list scroll and map command decoder
// Function
// - text scroll load reads hscroll then vscroll
// - text hscroll 0..7 pixels left
// - text vscroll 0..7 lines up
// - frame top clears both text scroll values
// - text scroll always on; load only stores
// - text hscroll step is one hires pixel
// - glyph base command reads one selector byte
// - font address is selector above eleven zeros
// - locate reads pointer three bytes, stride two
// - map pointer accepts any byte address
// - stride added after field's last line
// - map scroll values range 0..31
// - field sizes stored as size minus one
// - frame top: map scroll zero, sizes seven
// - map size and scroll accepted any line
// - map scroll and width step one pixel
// - map scroll always on; load only stores
package xdl_cmd_pkg;

    localparam int VRAM_ADDR_W = 19;
    localparam int STRIDE_W = 12;
    localparam int TEXT_SCROLL_W = 3;
    localparam int MAP_FIELD_W = 5;
    localparam int GLYPH_ZERO_BITS = 11;
    localparam int IDX_W = 3;

    // last operand index of each command
    localparam logic [IDX_W-1:0] TEXT_LAST_IDX = 3'h1;
    localparam logic [IDX_W-1:0] GLYPH_LAST_IDX = 3'h0;
    localparam logic [IDX_W-1:0] LOCATE_LAST_IDX = 3'h4;
    localparam logic [IDX_W-1:0] PARAMS_LAST_IDX = 3'h3;

    // reset defaults; scroll and field sizes also restored at frame top
    localparam logic [TEXT_SCROLL_W-1:0] TEXT_SCROLL_RESET = 3'h0;
    localparam logic [MAP_FIELD_W-1:0] MAP_SCROLL_RESET = 5'h00;
    localparam logic [MAP_FIELD_W-1:0] FIELD_SIZE_RESET = 5'h07;
    localparam logic [7:0] GLYPH_SEL_RESET = 8'h00;
    localparam logic [VRAM_ADDR_W-1:0] MAP_PTR_RESET = 19'h0_0000;
    localparam logic [STRIDE_W-1:0] STRIDE_RESET = 12'h000;

    typedef struct packed {
        logic text_scroll_load_cmd;
        logic glyph_base_cmd;
        logic attr_map_locate_cmd;
        logic attr_map_params_cmd;
    } cmd_flags_t;

    typedef struct packed {
        logic [TEXT_SCROLL_W-1:0] hscroll;
        logic [TEXT_SCROLL_W-1:0] vscroll;
    } text_scroll_t;

    typedef struct packed {
        logic [VRAM_ADDR_W-1:0] attr_map_pointer;
        logic [STRIDE_W-1:0] attr_map_stride;
        logic [MAP_FIELD_W-1:0] hscroll;
        logic [MAP_FIELD_W-1:0] vscroll;
        logic [MAP_FIELD_W-1:0] width;
        logic [MAP_FIELD_W-1:0] height;
    } attr_map_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_TEXT = 3'b001,
        ST_GLYPH = 3'b010,
        ST_LOCATE = 3'b011,
        ST_PARAMS = 3'b100
    } fetch_state_t;

endpackage

// ---- dv/xdl_list_mem.sv ----
// display-list memory model serving operand bytes on request
`timescale 1ns/10ps
`default_nettype none
module xdl_list_mem (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // operand fetch handshake
    input wire logic fetch_req,
    output logic fetch_ack,
    output logic [7:0] fetch_data,
    // most idle cycles between two bytes
    input wire logic [1:0] max_gap
);
    logic [7:0] bytes_q[$];
    logic [7:0] noise = 8'h5a;
    int gap = 0;
    task automatic load(input logic [7:0] b);
        bytes_q.push_back(b);
    endtask
    // idle data lines show a changing pattern instead of holding the last byte
    always @(negedge clock) begin
        noise = {noise[6:0], noise[7] ^ noise[5] ^ noise[4] ^ noise[3]};
        if (reset_n && fetch_req && bytes_q.size() > 0 && gap == 0) begin
            fetch_ack <= 1'b1;
            fetch_data <= bytes_q.pop_front();
            gap = noise % (max_gap + 1);
        end else begin
            fetch_ack <= 1'b0;
            fetch_data <= noise;
            if (!reset_n) begin
                gap = 0;
            end else if (fetch_req && bytes_q.size() > 0) begin
                gap--;
            end
        end
    end
endmodule // xdl_list_mem
`default_nettype wire

// ---- dv/xdl_scroll_map_cmds_tb.sv ----
// self-checking bench for the scroll, glyph and map command decoder
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module xdl_scroll_map_cmds_tb import xdl_cmd_pkg::*; ;
    typedef struct packed {
        text_scroll_t ts;
        logic [VRAM_ADDR_W-1:0] font;
        attr_map_t map;
    } note_t;
    logic clock, reset_n, frame_start, line_done, cmd_valid, cmd_ready;
    logic fetch_req, fetch_ack, snap, prev_rdy;
    logic [7:0] fetch_data;
    logic [1:0] max_gap;
    cmd_flags_t cmd_flags;
    text_scroll_t text_scroll;
    logic [VRAM_ADDR_W-1:0] font_addr;
    attr_map_t attr_map;
    note_t exp, got;
    note_t notes[$];
    int errors, total_checks, k;
    logic [31:0] rnd;

    xdl_scroll_map_cmds DUT (.clock(clock), .reset_n(reset_n), .frame_start(frame_start),
        .line_done(line_done), .cmd_valid(cmd_valid), .cmd_flags(cmd_flags),
        .cmd_ready(cmd_ready), .fetch_req(fetch_req), .fetch_ack(fetch_ack),
        .fetch_data(fetch_data), .text_scroll(text_scroll), .font_addr(font_addr),
        .attr_map(attr_map));
    xdl_list_mem mem (.clock(clock), .reset_n(reset_n), .fetch_req(fetch_req),
        .fetch_ack(fetch_ack), .fetch_data(fetch_data), .max_gap(max_gap));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    function automatic logic [7:0] rb(input logic edge_val);
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return edge_val ? 8'hff : rnd[7:0];
    endfunction

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check_now();
        notes.push_back(exp);
        snap = 1'b1;
        @(negedge clock);
        snap = 1'b0;
    endtask

    task automatic run_cmd(input cmd_flags_t f);
        int i;
        cmd_valid = 1'b1;
        cmd_flags = f;
        @(negedge clock);
        cmd_valid = 1'b0;
        for (i = 0; i < 200 && cmd_ready !== 1'b1; i++)
            @(negedge clock);
        if (i == 200) begin
            errors++;
            $display("unexpected cmd_ready expected 1 seen %b", cmd_ready);
            end_of_test();
        end
    endtask

    // queue operand bytes for every flagged command, in decode order
    task automatic issue(input cmd_flags_t f, input logic ev);
        logic [7:0] b [5];
        int i;
        if (f.text_scroll_load_cmd) begin
            b[0] = rb(ev);
            b[1] = rb(ev);
            mem.load(b[0]);
            mem.load(b[1]);
            exp.ts.hscroll = b[0][2:0];
            exp.ts.vscroll = b[1][2:0];
        end
        if (f.glyph_base_cmd) begin
            b[0] = rb(ev);
            mem.load(b[0]);
            exp.font = {b[0], 11'h000};
        end
        if (f.attr_map_locate_cmd) begin
            for (i = 0; i < 5; i++) begin
                b[i] = rb(ev);
                mem.load(b[i]);
            end
            exp.map.attr_map_pointer = {b[2][2:0], b[1], b[0]};
            exp.map.attr_map_stride = {b[4][3:0], b[3]};
        end
        if (f.attr_map_params_cmd) begin
            b[2] = rb(ev);
            b[3] = rb(ev);
            b[4] = rb(1'b0);
            b[0] = {3'h7, (b[2][4:0] == 5'h00) ? 5'h00 : b[4][4:0] % b[2][4:0]};
            b[1] = {3'h7, (b[3][4:0] == 5'h00) ? 5'h00 : b[4][7:3] % b[3][4:0]};
            for (i = 0; i < 4; i++)
                mem.load(b[i]);
            exp.map.hscroll = b[0][4:0];
            exp.map.vscroll = b[1][4:0];
            exp.map.width = b[2][4:0];
            exp.map.height = b[3][4:0];
        end
        notes.push_back(exp);
        run_cmd(f);
    endtask

    task automatic lines(input int n);
        repeat (n) begin
            line_done = 1'b1;
            @(negedge clock);
            line_done = 1'b0;
            @(negedge clock);
        end
    endtask

    // compare settings when a command completes or a snapshot is asked for
    always begin
        @(posedge clock);
        #2;
        if (reset_n && (snap || (cmd_ready && !prev_rdy))) begin
            if (notes.size() == 0) begin
                errors++;
                $display("unexpected result expected none seen one");
            end else begin
                got = notes.pop_front();
                `CHK("text_scroll", got.ts, text_scroll)
                `CHK("font_addr", got.font, font_addr)
                `CHK("attr_map", got.map, attr_map)
                `CHK("bytes_left", 0, mem.bytes_q.size())
                `CHK("fetch_req", 1'b0, fetch_req)
            end
        end
        prev_rdy = cmd_ready;
    end

    initial begin
        repeat (50000) @(posedge clock);
        errors++;
        $display("unexpected run_length expected finish seen hang");
        end_of_test();
    end

    initial begin
        rnd = 32'h668e;
        {reset_n, frame_start, line_done, cmd_valid, snap} = 5'h00;
        cmd_flags = 4'h0;
        max_gap = 2'h0;
        errors = 0;
        total_checks = 0;
        exp = '0;
        {exp.map.hscroll, exp.map.vscroll, exp.map.width, exp.map.height} = 20'h0_00e7;
        repeat (3) @(negedge clock);
        reset_n = 1'b1;
        check_now();
        $display("test reset done");
        run_cmd(4'h0);
        check_now();
        for (k = 0; k < 12; k++)
            issue(cmd_flags_t'(4'h1 << (k % 4)), k < 4);
        $display("test single commands done");
        max_gap = 2'h3;
        issue(4'hf, 1'b0);
        issue(4'hf, 1'b1);
        max_gap = 2'h0;
        $display("test combined commands done");
        issue(4'h2, 1'b0);
        frame_start = 1'b1;
        @(negedge clock);
        frame_start = 1'b0;
        exp.ts = 6'h00;
        {exp.map.hscroll, exp.map.vscroll, exp.map.width, exp.map.height} = 20'h0_00e7;
        check_now();
        issue(4'h8, 1'b0);
        lines(7);
        check_now();
        lines(1);
        exp.map.attr_map_pointer = exp.map.attr_map_pointer + exp.map.attr_map_stride;
        check_now();
        $display("test frame and field step done");
        end_of_test();
    end
endmodule // xdl_scroll_map_cmds_tb
`default_nettype wire
